// ### include/cvsg_cfg.svh
`ifndef CVSG_CFG_SVH
`define CVSG_CFG_SVH

// ============================================================
// Sizes
`define CVSG_NCHAN        8
`define CVSG_CHW          3
`define CVSG_CODEW        4
`define CVSG_SMPW         14
`define CVSG_OUTW         16
`define CVSG_ACCW         18
`define CVSG_GAINW        16
`define CVSG_GAIN_SHIFT   15

// ============================================================
// Register byte offsets
`define CVSG_OFS_STAGING  12'h000
`define CVSG_OFS_COMMAND  12'h004
`define CVSG_OFS_OPTION   12'h008
`define CVSG_OFS_STATUS   12'h00C
`define CVSG_OFS_CHAN0    12'h020
`define CVSG_CHAN_STRIDE  12'h004

// ============================================================
// Command register fields
`define CVSG_CMD_LSB      0
`define CVSG_CMD_MSB      1
`define CVSG_CMD_CH_LSB   4
`define CVSG_CMD_CH_MSB   6
`define CVSG_CMD_NONE     2'h0
`define CVSG_CMD_CHAN_ATT 2'h1
`define CVSG_CMD_BALANCE  2'h2

// ============================================================
// Staging field positions
`define CVSG_LOW_LSB      0
`define CVSG_LOW_MSB      3
`define CVSG_HIGH_LSB     4
`define CVSG_HIGH_MSB     7

// ============================================================
// Reset values: code zero is 0 dB
`define CVSG_ATT_RST      4'h0
`define CVSG_STAGING_RST  8'h00

`endif

// ### include/cvsg_pkg.sv
`include "cvsg_cfg.svh"

package cvsg_pkg;

  typedef logic [`CVSG_CODEW-1:0]            cvsg_code_t;
  typedef logic [`CVSG_GAINW-1:0]            cvsg_gain_t;
  typedef logic signed [`CVSG_SMPW-1:0]      cvsg_smp_t;
  typedef logic signed [`CVSG_OUTW-1:0]      cvsg_out_t;
  typedef logic signed [`CVSG_ACCW-1:0]      cvsg_acc_t;
  typedef logic [`CVSG_CHW-1:0]              cvsg_chan_t;
  typedef logic [`CVSG_NCHAN-1:0][`CVSG_CODEW-1:0] cvsg_att_arr_t;

  typedef struct packed {
    logic [7:0]    staging;
    cvsg_code_t    option_att;
    cvsg_att_arr_t chan_att;
    cvsg_att_arr_t left_att;
    cvsg_att_arr_t right_att;
    cvsg_acc_t     acc_l;
    cvsg_acc_t     acc_r;
    cvsg_out_t     out_l;
    cvsg_out_t     out_r;
    logic          clip;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } cvsg_state_t;

endpackage : cvsg_pkg

// ### hw/cvsg_gain_rom.sv
`timescale 1ns/1ps

// Attenuation code n to linear gain 10^(-n/10), unsigned Q1.15
module cvsg_gain_rom
  import cvsg_pkg::*;
(
  // Lookup
  input  cvsg_pkg::cvsg_code_t code,
  output cvsg_pkg::cvsg_gain_t gain
);

  import cvsg_pkg::*;

  // ============================================================
  // Table
  always_comb
  begin
    case (code)
      4'h0:    gain = 16'h8000;
      4'h1:    gain = 16'h65AD;
      4'h2:    gain = 16'h50C3;
      4'h3:    gain = 16'h4027;
      4'h4:    gain = 16'h32F5;
      4'h5:    gain = 16'h287A;
      4'h6:    gain = 16'h2027;
      4'h7:    gain = 16'h198A;
      4'h8:    gain = 16'h1449;
      4'h9:    gain = 16'h101D;
      4'hA:    gain = 16'h0CCD;
      4'hB:    gain = 16'h0A2B;
      4'hC:    gain = 16'h0814;
      4'hD:    gain = 16'h066A;
      4'hE:    gain = 16'h0519;
      4'hF:    gain = 16'h040C;
      default: gain = 16'h8000;
    endcase
  end

endmodule : cvsg_gain_rom

// ### hw/cvsg_top.sv
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "cvsg_cfg.svh"

// Function
// - Channel-volume command loads channel attenuation
// - Sixteen codes, each step minus 2 dB
// - Channel volume uses low nibble only
// - Reset sets every channel to 0 dB
// - Balance command loads left and right attenuation
// - Left from high nibble, right low
// - Side attenuations scale each output independently
// - Output is sample times option, channel, side
// - Global option attenuates all channels together
module cvsg_top
  import cvsg_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Sample stream from voice fetch
  input  wire logic                smp_valid,
  input  wire logic                smp_last,
  input  cvsg_pkg::cvsg_chan_t     smp_chan,
  input  cvsg_pkg::cvsg_smp_t      smp_data,
  // Mixed outputs towards the converter
  output cvsg_pkg::cvsg_out_t      left_analog_out,
  output cvsg_pkg::cvsg_out_t      right_analog_out,
  output logic                     mix_clip
);

  import cvsg_pkg::*;

  localparam int NREG = 5 + `CVSG_NCHAN;

  // ============================================================
  // Address decode: index 0..3 fixed, 4.. channel readback
  function automatic logic [4:0] reg_index(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - `CVSG_OFS_CHAN0;
    if (a[1:0] != 2'h0)
      reg_index = 5'h1F;
    else if (a < `CVSG_OFS_CHAN0)
      reg_index = (a[11:4] == 8'h00) ? {3'h0, a[3:2]} : 5'h1F;
    else if (rel[11:2] < 10'(`CVSG_NCHAN))
      reg_index = 5'(rel[11:2]) + 5'h04;
    else
      reg_index = 5'h1F;
  endfunction : reg_index

  // ============================================================
  // Saturate the mix to the output width
  function automatic cvsg_out_t clamp(input cvsg_acc_t v);
    if (v > cvsg_acc_t'(16'sh7FFF))
      clamp = 16'sh7FFF;
    else if (v < -cvsg_acc_t'(16'sh7FFF) - 18'sh00001)
      clamp = 16'sh8000;
    else
      clamp = v[`CVSG_OUTW-1:0];
  endfunction : clamp

  cvsg_state_t q;
  cvsg_state_t d;

  // ============================================================
  // Gain lookups: option, channel, left, right
  cvsg_code_t lut_code [4];
  cvsg_gain_t lut_gain [4];

  assign lut_code[0] = q.option_att;
  assign lut_code[1] = q.chan_att[smp_chan];
  assign lut_code[2] = q.left_att[smp_chan];
  assign lut_code[3] = q.right_att[smp_chan];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lut
      cvsg_gain_rom u_rom
      (
        .code (lut_code[gi]),
        .gain (lut_gain[gi])
      );
    end
  endgenerate

  // ============================================================
  // Gain chain; each gain product renormalised to Q1.15, sample products shifted back by 15
  logic [31:0]  prod_oc;
  cvsg_gain_t   gain_oc;
  logic [31:0]  prod_l;
  logic [31:0]  prod_r;
  cvsg_gain_t   gain_l;
  cvsg_gain_t   gain_r;
  logic signed [30:0] scaled_l;
  logic signed [30:0] scaled_r;
  cvsg_acc_t    contrib_l;
  cvsg_acc_t    contrib_r;

  always_comb
  begin
    prod_oc   = lut_gain[0] * lut_gain[1];
    gain_oc   = prod_oc[`CVSG_GAIN_SHIFT +: `CVSG_GAINW];
    prod_l    = gain_oc * lut_gain[2];
    prod_r    = gain_oc * lut_gain[3];
    gain_l    = prod_l[`CVSG_GAIN_SHIFT +: `CVSG_GAINW];
    gain_r    = prod_r[`CVSG_GAIN_SHIFT +: `CVSG_GAINW];
    scaled_l  = 31'(smp_data * $signed({1'b0, gain_l}));
    scaled_r  = 31'(smp_data * $signed({1'b0, gain_r}));
    contrib_l = cvsg_acc_t'(scaled_l >>> `CVSG_GAIN_SHIFT);
    contrib_r = cvsg_acc_t'(scaled_r >>> `CVSG_GAIN_SHIFT);
  end

  // ============================================================
  // Bus and mixing next state
  logic        acc_phase;
  logic        wr_take;
  logic        rd_take;
  logic [4:0]  idx;
  logic [1:0]  cmd;
  cvsg_chan_t  cmd_ch;
  cvsg_acc_t   sum_l;
  cvsg_acc_t   sum_r;
  int          ci;

  always_comb
  begin
    d         = q;
    acc_phase = psel && penable && !q.pready;
    idx       = reg_index(paddr);
    wr_take   = acc_phase && pwrite && (idx < 5'(NREG)) && idx != 5'h03;
    rd_take   = acc_phase && !pwrite && (idx < 5'(NREG));
    cmd       = pwdata[`CVSG_CMD_MSB:`CVSG_CMD_LSB];
    cmd_ch    = pwdata[`CVSG_CMD_CH_MSB:`CVSG_CMD_CH_LSB];
    sum_l     = q.acc_l + contrib_l;
    sum_r     = q.acc_r + contrib_r;
    ci        = 0;

    // One wait state: answer on the second access cycle
    d.pready  = acc_phase;
    d.pslverr = acc_phase && !(wr_take || rd_take);
    d.prdata  = 32'h0000_0000;

    if (wr_take)
    begin
      case (idx)
        5'h00: d.staging    = pwdata[7:0];
        5'h01:
        begin
          // Command write stands in for the strobe's rising edge
          if (cmd == `CVSG_CMD_CHAN_ATT)
            d.chan_att[cmd_ch] =
              q.staging[`CVSG_LOW_MSB:`CVSG_LOW_LSB];
          else if (cmd == `CVSG_CMD_BALANCE)
          begin
            d.left_att[cmd_ch]  =
              q.staging[`CVSG_HIGH_MSB:`CVSG_HIGH_LSB];
            d.right_att[cmd_ch] =
              q.staging[`CVSG_LOW_MSB:`CVSG_LOW_LSB];
          end
        end
        5'h02: d.option_att = pwdata[`CVSG_CODEW-1:0];
        default: d.option_att = q.option_att;
      endcase
    end

    if (rd_take)
    begin
      case (idx)
        5'h00: d.prdata = {24'h00_0000, q.staging};
        5'h01: d.prdata = 32'h0000_0000;
        5'h02: d.prdata = {28'h000_0000, q.option_att};
        5'h03: d.prdata = {15'h0000, q.clip, q.out_l};
        default:
        begin
          ci = int'(idx) - 4;
          d.prdata = {20'h0_0000, q.right_att[ci[2:0]],
                      q.left_att[ci[2:0]], q.chan_att[ci[2:0]]};
        end
      endcase
    end

    // Mix all channel contributions of one frame
    if (smp_valid)
    begin
      if (smp_last)
      begin
        d.out_l = clamp(sum_l);
        d.out_r = clamp(sum_r);
        d.clip  = (clamp(sum_l) != sum_l[`CVSG_OUTW-1:0]) ||
                  (sum_l != cvsg_acc_t'(clamp(sum_l))) ||
                  (sum_r != cvsg_acc_t'(clamp(sum_r)));
        d.acc_l = '0;
        d.acc_r = '0;
      end
      else
      begin
        d.acc_l = sum_l;
        d.acc_r = sum_r;
      end
    end
  end

  // ============================================================
  // State register; every attenuation resets to 0 dB
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q            <= '0;
      q.staging    <= `CVSG_STAGING_RST;
      q.option_att <= `CVSG_ATT_RST;
      q.chan_att   <= {`CVSG_NCHAN{`CVSG_ATT_RST}};
      q.left_att   <= {`CVSG_NCHAN{`CVSG_ATT_RST}};
      q.right_att  <= {`CVSG_NCHAN{`CVSG_ATT_RST}};
    end
    else
      q <= d;
  end

  // ============================================================
  // Outputs straight from the state register
  assign pready           = q.pready;
  assign prdata           = q.prdata;
  assign pslverr          = q.pslverr;
  assign left_analog_out  = q.out_l;
  assign right_analog_out = q.out_r;
  assign mix_clip         = q.clip;

endmodule : cvsg_top

// ### verif/cvsg_props.sv
`timescale 1ns/1ps
// ========
// Bus and mix output checks
module cvsg_props
  import cvsg_pkg::*;
(
  // Clock
  input wire logic           pclk,
  input wire logic           presetn,
  // Bus
  input wire logic           psel,
  input wire logic           penable,
  input wire logic [11:0]    paddr,
  input wire logic           pready,
  input wire logic [31:0]    prdata,
  input wire logic           pslverr,
  // Mix
  input wire logic           smp_valid,
  input wire logic           smp_last,
  input cvsg_pkg::cvsg_out_t left_analog_out,
  input cvsg_pkg::cvsg_out_t right_analog_out
);
  wire logic acc = psel && penable && !pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  access_answer_a: assert property (acc |=> pready && psel && penable)
    else $error("access not answered");
  pready_cause_a: assert property (pready |-> $past(acc))
    else $error("pready without access");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("error flag without pready");
  unalign_err_a: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access accepted");
  out_hold_a: assert property (
    !(smp_valid && smp_last) |=>
    $stable(left_analog_out) && $stable(right_analog_out))
    else $error("mix outputs moved outside frame end");
  reset_out_a: assert property ($rose(presetn) |->
    left_analog_out == 16'h0 && right_analog_out == 16'h0)
    else $error("mix outputs not cleared by reset");
endmodule : cvsg_props

bind cvsg_top cvsg_props u_cvsg_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .smp_valid(smp_valid),
  .smp_last(smp_last), .left_analog_out(left_analog_out),
  .right_analog_out(right_analog_out));

// ### verif/cvsg_src.sv
`timescale 1ns/1ps
// ========
// Voice fetch stand-in: frame ends on the sample marked by req_last
module cvsg_src
  import cvsg_pkg::*;
(
  // Clock and request
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            req,
  input  wire logic            req_last,
  input  cvsg_pkg::cvsg_chan_t req_chan,
  input  cvsg_pkg::cvsg_smp_t  req_data,
  // Stream
  output logic                 smp_valid,
  output logic                 smp_last,
  output cvsg_pkg::cvsg_chan_t smp_chan,
  output cvsg_pkg::cvsg_smp_t  smp_data
);
  // Idle lines toggle so a stale sample never looks steady
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      smp_valid <= 1'b0;
      smp_last  <= 1'b0;
      smp_chan  <= '0;
      smp_data  <= '0;
    end
    else
    begin
      smp_valid <= req;
      smp_last  <= req && req_last;
      smp_chan  <= req ? req_chan : ~smp_chan;
      smp_data  <= req ? req_data : ~smp_data;
    end
endmodule : cvsg_src

// ### verif/testbench.sv
`timescale 1ns/1ps
// ========
// Volume and balance bench
module testbench;
  import cvsg_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, req = 1'b0, pready, pslverr, e;
  logic        smp_valid, smp_last, mix_clip, req_last = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  cvsg_chan_t  smp_chan;
  cvsg_smp_t   smp_data;
  cvsg_out_t   lo, ro;
  int          mismatches = 0, n_compared = 0;

  always #5 pclk = ~pclk;

  cvsg_top u_cvsg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .smp_valid(smp_valid), .smp_last(smp_last), .smp_chan(smp_chan),
    .smp_data(smp_data), .left_analog_out(lo), .right_analog_out(ro),
    .mix_clip(mix_clip));
  cvsg_src u_cvsg_src (.pclk(pclk), .presetn(presetn), .req(req),
    .req_last(req_last), .req_chan(3'h3), .req_data(14'h1F40),
    .smp_valid(smp_valid),
    .smp_last(smp_last), .smp_chan(smp_chan), .smp_data(smp_data));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) check(1'b0, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input int c, input logic [1:0] op, input logic [7:0] s);
    apb(1'b1, 12'h000, {24'h0, s});
    apb(1'b1, 12'h004, {25'h0, 3'(c), 2'h0, op});
  endtask : cmd

  // Frame of k samples of 8000 on channel 3, outputs settled on return
  task automatic frame(input int k);
    for (int i = 1; i <= k; i++)
    begin
      @(posedge pclk);
      req      <= 1'b1;
      req_last <= (i == k);
    end
    @(posedge pclk);
    req      <= 1'b0;
    req_last <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : frame

  // Within 3 of 8000 attenuated by n steps of 2 dB
  function automatic logic near(input cvsg_out_t v, input int n);
    return $unsigned(v - $rtoi(8.0e3 * 10.0 ** (-n / 10.0)) + 3) < 7;
  endfunction : near

  task automatic t_reset;
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b0, 12'h020 + 12'(4 * c), 32'h0);
      check(q, 32'h0);
    end
    apb(1'b0, 12'h002, 32'h0);
    check(e, 1'b1);
    apb(1'b1, 12'h00C, 32'h1);
    check(e, 1'b1);
  endtask : t_reset

  task automatic t_channel_attenuation_cmd;
    for (int c = 0; c < 8; c++)
    begin
      cmd(c, 2'h1, {4'(~c), 4'(c + 8)});
      apb(1'b0, 12'h020 + 12'(4 * c), 32'h0);
      check(q, 32'(c + 8));
    end
  endtask : t_channel_attenuation_cmd

  task automatic t_pan;
    cmd(5, 2'h2, 8'h3C);
    apb(1'b0, 12'h034, 32'h0);
    check(q, 32'hC3D);
    for (int op = 0; op < 4; op += 3)
    begin
      cmd(5, 2'(op), 8'h77);
      apb(1'b0, 12'h034, 32'h0);
      check(q, 32'hC3D);
    end
  endtask : t_pan

  task automatic t_level;
    cmd(3, 2'h2, 8'h00);
    for (int n = 0; n < 16; n++)
    begin
      cmd(3, 2'h1, 8'(n));
      frame(1);
      check(near(lo, n), 1'b1);
      check(near(ro, n), 1'b1);
    end
    apb(1'b0, 12'h00C, 32'h0);
    check(q[16], 1'b0);
    check(near(q[15:0], 15), 1'b1);
    cmd(3, 2'h1, 8'h00);
    cmd(3, 2'h2, 8'h0F);
    frame(1);
    check(near(lo, 0), 1'b1);
    check(near(ro, 15), 1'b1);
    check(mix_clip, 1'b0);
    cmd(3, 2'h2, 8'h00);
    // Five samples of 8000 at 0 dB overflow the output width
    frame(5);
    check(lo, 16'h7FFF);
    check(ro, 16'h7FFF);
    check(mix_clip, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    check(q, 32'h0001_7FFF);
    apb(1'b1, 12'h008, 32'h5);
    frame(1);
    check(mix_clip, 1'b0);
    check(near(lo, 5), 1'b1);
    check(near(ro, 5), 1'b1);
  endtask : t_level

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_channel_attenuation_cmd();
    t_pan();
    t_level();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    conclude();
  end

  // Run needs about 500 cycles; allow ten times that
  initial
  begin
    #50000;
    check(1'b0, 1'b1);
    conclude();
  end
endmodule : testbench
